// file: hw/flash_status_latency.sv
// Flash status polling and burst latency engine with Wishbone registers
`timescale 1ns/1ps
// What this block and its host do
// [RULE_01] In asynchronous mode the address is taken at the rising edge of the address strobe.
// [RULE_02] In synchronous mode the address is taken at a bus clock edge and latency counts from it.
// [RULE_03] The host reads status twice before judging whether a sequence still runs.
// [RULE_04] While a sequence runs the polled bit is the complement of the target data.
// [RULE_05] Toggle bits change on each status read while running and hold once done.
// [RULE_06] The suspend toggle bit moves only for reads inside an erase-suspended sector.
// [RULE_07] Status reads are delimited by either output enable or chip select cycling.
// [RULE_08] Ready timing bit clear gives ready with data, set gives ready one clock early.
// [RULE_09] The four-bit wait code picks first data on the 2nd to 7th or 8th to 13th edge.
// [RULE_10] Software does not program the reserved wait codes.
// [RULE_11] Bursts crossing a 128-word boundary get extra latency shown on ready.
// [RULE_12] Reads of a non-busy bank are served normally while another bank is busy.
// [RULE_13] Program to a protected sector toggles status for about 1 us, data unchanged.
// [RULE_14] The host programs a wait count matched to its bus clock.
// [RULE_15] The host holds off sampling data while ready is low.
// [RULE_16] The host judges completion from two identical back-to-back toggle reads.
module flash_status_latency
    import flash_status_pkg::*;
#(
    parameter int BANK_LSB = 22,
    parameter int SECT_LSB = 14
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic bus_clk_i,
    input wire logic chip_select_n_i,
    input wire logic address_valid_strobe_n_i,
    input wire logic output_enable_n_i,
    input wire logic write_enable_n_i,
    input wire logic [DATA_W-1:0] adq_i,
    output logic [DATA_W-1:0] adq_o,
    output logic adq_oe_o,
    output logic ready_o,
    output logic ready_oe_o,
    input wire logic [DATA_W-1:0] array_data_i,
    output logic [ADDR_W-1:0] array_addr_o
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    bus_pins_s meta_q, pins_q, prev_q;

    // Two flops before any logic looks at the pins
    always_ff @(posedge clk_i) begin
        meta_q <= '{bus_clk_i, chip_select_n_i, address_valid_strobe_n_i,
                    output_enable_n_i, write_enable_n_i, adq_i};
        pins_q <= meta_q;
        prev_q <= pins_q;
    end

    logic clk_rise;
    logic avd_rise;
    logic oe_rise;
    logic ce_rise;
    logic oe_fall;
    assign clk_rise = pins_q.clk & ~prev_q.clk;
    assign avd_rise = pins_q.avd_n & ~prev_q.avd_n;
    assign oe_rise = pins_q.oe_n & ~prev_q.oe_n;
    assign ce_rise = pins_q.ce_n & ~prev_q.ce_n;
    assign oe_fall = ~pins_q.oe_n & prev_q.oe_n;

    // ****************************************************************
    // Configuration decode
    // ****************************************************************
    logic [15:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d;
    op_state_s op_q, op_d;
    logic prot_req_q, prot_req_d;
    logic [2:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;

    // Wait code to edges of first data: 0000->2 .. 1101->13
    function automatic logic [3:0] first_edge(input logic [3:0] code);
        first_edge = code[3] ? 4'(code[2:0] + 3'h0) + 4'h8 : 4'(code[2:0]) + 4'h2;
    endfunction

    logic [3:0] wait_code;
    logic early_rdy;
    assign wait_code = {cfg1_q[0], cfg0_q[WAIT_HI_BIT:WAIT_LO_BIT]}; // [RULE_09] [RULE_10]
    assign early_rdy = cfg0_q[RDY_TIMING_BIT];

    // ****************************************************************
    // Burst sequencer
    // ****************************************************************
    burst_state_e st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic sync_mode;
    logic new_addr;
    logic [ADDR_W-1:0] cap_addr;
    assign sync_mode = ~cfg0_q[15];
    // Sync mode takes the address at a clock edge while the strobe is low
    assign new_addr = ~pins_q.ce_n & (sync_mode ? (clk_rise & ~pins_q.avd_n) : avd_rise);
    assign cap_addr = {addr_q[ADDR_W-1:DATA_W], pins_q.adq};

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        if (pins_q.ce_n) begin
            st_d = ST_IDLE;
        end else if (new_addr) begin
            addr_d = cap_addr; // [RULE_01] [RULE_02]
            st_d = sync_mode ? ST_LATENCY : ST_ASYNC;
            cnt_d = 4'h1; // Capture edge counts as edge one; next edge is 2
        end else if (clk_rise) begin
            case (st_q)
                ST_LATENCY: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == first_edge(wait_code) - 4'h1) begin
                        st_d = ST_DATA; // [RULE_02]
                    end
                end
                ST_DATA: begin
                    addr_d = addr_q + 24'h1;
                    if (addr_q[6:0] == BOUNDARY_LAST) begin
                        st_d = ST_EXTRA; // [RULE_11]
                        cnt_d = 4'h0;
                    end
                end
                ST_EXTRA: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == 4'(BOUNDARY_EXTRA - 1)) begin
                        st_d = ST_DATA;
                    end
                end
                default: begin
                    st_d = st_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            addr_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
        end
    end

    // ****************************************************************
    // Internal sequence state and status word
    // ****************************************************************
    logic [7:0] prot_cnt_q, prot_cnt_d;
    logic hits_busy;
    logic in_susp;
    logic seq_active;
    logic advance;
    logic [DATA_W-1:0] status;
    assign hits_busy = op_q.busy && addr_q[BANK_LSB +: BANK_W] == op_q.busy_bank; // [RULE_12]
    assign in_susp = op_q.suspended && addr_q[SECT_LSB +: SECT_W] == op_q.susp_sector;
    assign seq_active = op_q.busy | (prot_cnt_q != 8'h00);
    assign advance = oe_rise | ce_rise; // [RULE_07]

    status_word u_status (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .advance_i(advance && (hits_busy || in_susp || prot_cnt_q != 8'h00)),
        .seq_active_i(seq_active),
        .in_susp_sector_i(in_susp),
        .target_i(op_q.target_data),
        .status_o(status)
    );

    // Protected program: brief toggling only, array untouched
    always_comb begin
        prot_cnt_d = prot_cnt_q;
        if (prot_req_q) begin
            prot_cnt_d = 8'(PROT_TOGGLE_CYC); // [RULE_13]
        end else if (prot_cnt_q != 8'h00) begin
            prot_cnt_d = prot_cnt_q - 8'h01;
        end
    end

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    logic [DATA_W-1:0] adq_d;
    logic adq_oe_d, rdy_d, rdy_oe_d;
    logic data_phase;
    logic rdy_early_hit;
    assign data_phase = st_q == ST_DATA || st_q == ST_ASYNC;
    assign rdy_early_hit = st_q == ST_LATENCY && cnt_q == first_edge(wait_code) - 4'h1;

    // Busy-bank, suspended-sector and protected-window reads see status, others the array
    always_comb begin
        adq_d = (hits_busy || in_susp || prot_cnt_q != 8'h00) ? status : array_data_i; // [RULE_04]
        adq_oe_d = ~pins_q.oe_n & ~pins_q.ce_n & data_phase;
        rdy_oe_d = ~pins_q.ce_n;
        if (early_rdy) begin
            rdy_d = data_phase | rdy_early_hit; // [RULE_08]
        end else begin
            rdy_d = data_phase; // [RULE_08]
        end
        if (st_q == ST_DATA && addr_q[6:0] == BOUNDARY_LAST && early_rdy) begin
            rdy_d = 1'b0; // [RULE_11]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adq_o <= '0;
            adq_oe_o <= 1'b0;
            ready_o <= 1'b0;
            ready_oe_o <= 1'b0;
            prot_cnt_q <= 8'h00;
            array_addr_o <= '0;
        end else begin
            adq_o <= adq_d;
            adq_oe_o <= adq_oe_d;
            ready_o <= rdy_d;
            ready_oe_o <= rdy_oe_d;
            prot_cnt_q <= prot_cnt_d;
            array_addr_o <= addr_q;
        end
    end

    // ****************************************************************
    // Wishbone slave and interrupts
    // ****************************************************************
    logic ack_d;
    logic [31:0] rdat_d;
    logic wr;
    logic [7:0] off;
    logic was_active_q;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign off = wb_adr_i[7:0];

    // Register writes; hardware set wins over software clear
    always_comb begin
        cfg0_d = cfg0_q;
        cfg1_d = cfg1_q;
        op_d = op_q;
        prot_req_d = 1'b0;
        irq_en_d = irq_en_q;
        irq_stat_d = irq_stat_q;
        if (wr) begin
            case (off)
                OFS_CFG0: cfg0_d = wb_dat_i[15:0];
                OFS_CFG1: cfg1_d = wb_dat_i[15:0];
                OFS_OP: begin
                    // Every field placed explicitly; no bit-stream cast of the word
                    op_d.target_data = wb_dat_i[DATA_W-1:0];
                    op_d.busy = wb_dat_i[31];
                    op_d.busy_bank = wb_dat_i[30:29];
                    op_d.suspended = wb_dat_i[28];
                    op_d.susp_sector = wb_dat_i[27:20];
                    prot_req_d = wb_dat_i[19];
                end
                OFS_IRQ_EN: irq_en_d = wb_dat_i[2:0];
                OFS_IRQ_CLR: irq_stat_d = irq_stat_q & ~wb_dat_i[2:0];
                default: begin
                end
            endcase
        end
        if (was_active_q && !seq_active) begin
            irq_stat_d[IRQ_DONE] = 1'b1;
        end
        if (prot_req_q) begin
            irq_stat_d[IRQ_PROT] = 1'b1;
        end
        if (new_addr) begin
            irq_stat_d[IRQ_ADDR] = 1'b1;
        end
    end

    // Read mux; unmapped offsets read zero and still ack
    always_comb begin
        ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        case (off)
            OFS_CFG0: rdat_d = {16'h0000, cfg0_q};
            OFS_CFG1: rdat_d = {16'h0000, cfg1_q};
            OFS_OP: rdat_d = {op_q.busy, op_q.busy_bank, op_q.suspended,
                              op_q.susp_sector, 4'h0, op_q.target_data};
            OFS_STATUS: rdat_d = {8'h00, addr_q[15:0], 5'h00, st_q};
            OFS_IRQ_STAT: rdat_d = {29'h0, irq_stat_q};
            OFS_IRQ_EN: rdat_d = {29'h0, irq_en_q};
            default: rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg0_q <= CFG0_RESET;
            cfg1_q <= CFG1_RESET;
            op_q <= '0;
            prot_req_q <= 1'b0;
            irq_en_q <= 3'h0;
            irq_stat_q <= 3'h0;
            was_active_q <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end else begin
            cfg0_q <= cfg0_d;
            cfg1_q <= cfg1_d;
            op_q <= op_d;
            prot_req_q <= prot_req_d;
            irq_en_q <= irq_en_d;
            irq_stat_q <= irq_stat_d;
            was_active_q <= seq_active;
            wb_ack_o <= ack_d;
            wb_dat_o <= rdat_d;
            irq_o <= |(irq_stat_d & irq_en_d);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    p_async_capture: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
        !sync_mode && avd_rise && !pins_q.ce_n |=> addr_q[15:0] == $past(pins_q.adq))
        else $error("async address not captured");
    sequence s_latency_done;
        st_q == ST_LATENCY && clk_rise && cnt_q == first_edge(wait_code) - 4'h1;
    endsequence
    p_first_data: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02] [RULE_09]
        s_latency_done and (!pins_q.ce_n && !new_addr) |=> st_q == ST_DATA)
        else $error("first data edge wrong");
    p_ready_with_data: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        !early_rdy && st_q == ST_LATENCY |=> !ready_o)
        else $error("ready before data when timing bit clear");
    p_boundary: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_11]
        st_q == ST_DATA && clk_rise && addr_q[6:0] == BOUNDARY_LAST && !pins_q.ce_n
        && !new_addr |=> st_q == ST_EXTRA)
        else $error("boundary latency missing");
    p_prot_window: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_13]
        prot_req_q |=> prot_cnt_q == 8'(PROT_TOGGLE_CYC))
        else $error("protected toggle window wrong");
    p_other_bank: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_12]
        !hits_busy && !in_susp && prot_cnt_q == 8'h00 |=> adq_o == $past(array_data_i))
        else $error("non-busy bank read not served");
    p_poll_complement: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        hits_busy |=> adq_o[STATUS_POLL_BIT] == !$past(op_q.target_data[STATUS_POLL_BIT]))
        else $error("polled bit not complemented");
    p_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    logic unused_oe_fall;
    assign unused_oe_fall = oe_fall;

endmodule

// file: inc/flash_status_pkg.sv
// Shared constants, types and register map for the flash status and latency block
package flash_status_pkg;

    // ********************************************************************
    // Bus geometry
    // ********************************************************************
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BANK_W = 2;
    localparam int SECT_W = 8;

    // ********************************************************************
    // Wishbone register byte offsets
    // ********************************************************************
    localparam logic [7:0] OFS_CFG0 = 8'h00;
    localparam logic [7:0] OFS_CFG1 = 8'h04;
    localparam logic [7:0] OFS_OP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;

    // ********************************************************************
    // Field positions and reset values
    // ********************************************************************
    localparam int RDY_TIMING_BIT = 8;
    localparam int WAIT_HI_BIT = 13;
    localparam int WAIT_LO_BIT = 11;
    localparam logic [15:0] CFG0_RESET = 16'h6800;
    localparam logic [15:0] CFG1_RESET = 16'h0001;
    localparam int STATUS_POLL_BIT = 7;
    localparam int BUSY_TOGGLE_POS = 6;
    localparam int SUSPEND_TOGGLE_POS = 2;
    localparam int BOUNDARY_WORDS = 128;
    localparam logic [6:0] BOUNDARY_LAST = 7'h7F;
    localparam int BOUNDARY_EXTRA = 2;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_MHZ = 125;
    localparam int PROT_TOGGLE_US = 1;
    localparam int PROT_TOGGLE_CYC = PROT_TOGGLE_US * CLK_MHZ;

    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_PROT = 1;
    localparam int IRQ_ADDR = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LATENCY = 3'b001,
        ST_DATA = 3'b011,
        ST_EXTRA = 3'b010,
        ST_ASYNC = 3'b110
    } burst_state_e;

    // Bus pins after synchronisation
    typedef struct packed {
        logic clk;
        logic ce_n;
        logic avd_n;
        logic oe_n;
        logic we_n;
        logic [DATA_W-1:0] adq;
    } bus_pins_s;

    // Internal sequence status as seen by the read path
    typedef struct packed {
        logic busy;
        logic [BANK_W-1:0] busy_bank;
        logic suspended;
        logic [SECT_W-1:0] susp_sector;
        logic [DATA_W-1:0] target_data;
    } op_state_s;

endpackage

// file: hw/status_word.sv
// Status word formation for reads of a busy bank, a suspended sector or a protected-program window
`timescale 1ns/1ps
module status_word
    import flash_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic advance_i,
    input wire logic seq_active_i,
    input wire logic in_susp_sector_i,
    input wire logic [DATA_W-1:0] target_i,
    output logic [DATA_W-1:0] status_o
);

    logic busy_tgl_q;
    logic busy_tgl_d;
    logic susp_tgl_q;
    logic susp_tgl_d;

    // Toggles advance once per delimited read: busy toggle only while running, suspend toggle only in the suspended sector
    always_comb begin
        busy_tgl_d = busy_tgl_q;
        susp_tgl_d = susp_tgl_q;
        if (advance_i && seq_active_i) begin
            busy_tgl_d = ~busy_tgl_q; // [RULE_05] [RULE_07]
        end
        if (advance_i && in_susp_sector_i) begin
            susp_tgl_d = ~susp_tgl_q; // [RULE_06]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_tgl_q <= 1'b0;
            susp_tgl_q <= 1'b0;
        end else begin
            busy_tgl_q <= busy_tgl_d;
            susp_tgl_q <= susp_tgl_d;
        end
    end

    // Polled bit complemented, toggle bits inserted
    always_comb begin
        status_o = target_i;
        status_o[STATUS_POLL_BIT] = ~target_i[STATUS_POLL_BIT]; // [RULE_04]
        status_o[BUSY_TOGGLE_POS] = busy_tgl_q;
        status_o[SUSPEND_TOGGLE_POS] = susp_tgl_q;
    end

    p_busy_toggles: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        advance_i && seq_active_i |=> busy_tgl_q != $past(busy_tgl_q))
        else $error("busy toggle did not advance");
    p_busy_steady: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        !seq_active_i |=> $stable(busy_tgl_q))
        else $error("busy toggle moved while idle");
    p_susp_only_in_sector: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        !in_susp_sector_i |=> $stable(susp_tgl_q))
        else $error("suspend toggle moved outside suspended sector");

endmodule

// file: verif/host_model.sv
// Host memory controller model driving the multiplexed burst bus
`timescale 1ns/1ps
module host_model
    import flash_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic [DATA_W-1:0] adq_dev_i,
    input wire logic adq_oe_i,
    input wire logic ready_i,
    output logic bus_clk_o,
    output logic ce_n_o,
    output logic avd_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [DATA_W-1:0] adq_drv_o
);
    logic run;

    // ********
    // Bus clock
    // ********
    // Free of the system clock phase; parked low outside frames
    initial begin
        {run, bus_clk_o, ce_n_o, avd_n_o, oe_n_o, we_n_o} = 6'b001111;
        adq_drv_o = '0;
        #3;
        forever begin
            #80;
            bus_clk_o <= run ? ~bus_clk_o : 1'b0; // Slow clock suits any wait code
        end
    end

    // One asynchronous status or array read, closed by oe and optionally ce
    task automatic rd(input logic [15:0] a, input logic ce_cyc, output logic [15:0] d);
        @(posedge clk_i);
        ce_n_o <= 1'b0;
        avd_n_o <= 1'b0;
        adq_drv_o <= a;
        repeat (4) @(posedge clk_i);
        avd_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        adq_drv_o <= ~a; // Released bus shows the inverse, not a stale address
        oe_n_o <= 1'b0;
        repeat (12) @(posedge clk_i);
        d = adq_oe_i ? adq_dev_i : 'x;
        oe_n_o <= 1'b1;
        if (ce_cyc) begin
            ce_n_o <= 1'b1;
        end
        repeat (4) @(posedge clk_i);
    endtask

    // Synchronous burst; ready is recorded after each bus clock rise
    task automatic burst(input logic [15:0] a, output logic [15:0] rv);
        rv = '0;
        ce_n_o <= 1'b0;
        avd_n_o <= 1'b0;
        adq_drv_o <= a;
        #100;
        run <= 1'b1;
        @(posedge bus_clk_o);
        #20;
        avd_n_o <= 1'b1;
        adq_drv_o <= ~a;
        oe_n_o <= 1'b0;
        for (int i = 1; i < 16; i++) begin
            @(posedge bus_clk_o);
            #120;
            rv[i] = ready_i; // Words count only where ready is high
        end
        oe_n_o <= 1'b1;
        ce_n_o <= 1'b1;
        run <= 1'b0;
        #400;
    endtask
endmodule

// file: verif/tb_flash_status_latency.sv
// Self-checking bench for the flash status and latency block
`timescale 1ns/1ps
module tb_flash_status_latency
    import flash_status_pkg::*;
;
    logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, wb_ack, irq, bclk, ce_n, avd_n, oe_n, we_n;
    logic adq_oe, rdy, rdy_oe, rt;
    logic [31:0] wb_adr, wb_dat, wb_rdat, rd_d;
    logic [15:0] adq_dev, adq_h, adq_pin, array_data, rv, ev, s0, s1;
    logic [23:0] arr_a;
    int errors = 0;
    int check_count = 0;
    int lat;

    // Array contents seen by the device
    function automatic logic [15:0] arr(input logic [15:0] a);
        return a ^ 16'hA5C3;
    endfunction
    assign array_data = arr(arr_a[15:0]);
    assign adq_pin = adq_oe ? adq_dev : adq_h;

    flash_status_latency #(.BANK_LSB(14), .SECT_LSB(8)) i_flash_status_latency (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rdat), .wb_we_i(wb_we), .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .irq_o(irq), .bus_clk_i(bclk),
        .chip_select_n_i(ce_n), .address_valid_strobe_n_i(avd_n), .output_enable_n_i(oe_n),
        .write_enable_n_i(we_n), .adq_i(adq_pin), .adq_o(adq_dev), .adq_oe_o(adq_oe),
        .ready_o(rdy), .ready_oe_o(rdy_oe), .array_data_i(array_data), .array_addr_o(arr_a));

    host_model i_host_model (.clk_i(clk_i), .adq_dev_i(adq_dev), .adq_oe_i(adq_oe),
        .ready_i(rdy), .bus_clk_o(bclk), .ce_n_o(ce_n), .avd_n_o(avd_n), .oe_n_o(oe_n),
        .we_n_o(we_n), .adq_drv_o(adq_h));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Classic Wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_adr <= {24'h0, a};
        wb_we <= we;
        wb_dat <= d;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd_d = (n < 50) ? wb_rdat : 'x;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // ********
    // Clock and watchdog
    // ********
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Tests need some 50 us; a hang is cut well after that
    initial begin
        #400000;
        errors++;
        conclude();
    end

    // ********
    // Test sequence
    // ********
    initial begin
        {rst_i, wb_we, wb_cyc, wb_stb, wb_adr, wb_dat} = {1'b1, 3'b0, 64'h0};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, OFS_CFG0, 0);
        chk("cfg0 reset", rd_d, {16'h0, CFG0_RESET});
        wb(0, OFS_CFG1, 0);
        chk("cfg1 reset", rd_d, {16'h0, CFG1_RESET});
        wb(0, 8'h40, 0);
        chk("unmapped", rd_d, 0);
        $display("test reset values done");
        // Every legal wait code, alternating ready timing
        for (int c = 0; c < 14; c++) begin
            if (c == 6 || c == 7) continue; // Reserved codes stay unused
            rt = c[0];
            lat = (c < 6) ? c + 2 : c;
            wb(1, OFS_CFG0, {18'h0, c[2:0], 2'b0, rt, 8'h0});
            wb(1, OFS_CFG1, {31'h0, c[3]});
            i_host_model.burst(16'h0010, rv);
            // Sample after edge i shows ready as the host meets it at edge i+1
            ev = (16'hFFFF << (lat - 1 - int'(rt))) & 16'hFFFE;
            chk("first ready", rv, ev);
        end
        // Boundary crossing adds two low-ready bus clocks
        wb(1, OFS_CFG0, 0);
        wb(1, OFS_CFG1, 0);
        i_host_model.burst(16'h007E, rv);
        chk("boundary 7E", rv, 16'hFFE6);
        i_host_model.burst(16'h007F, rv);
        chk("boundary 7F", rv, 16'hFFF2);
        $display("test burst latency done");
        // Status polling in asynchronous mode, bank 0 busy, sector 03 suspended
        wb(1, OFS_CFG0, 32'h0000E800);
        wb(1, OFS_OP, 32'h9030_1234);
        i_host_model.rd(16'h0305, 1'b0, s0);
        i_host_model.rd(16'h0305, 1'b0, s1); // Two reads before judging
        chk("poll bit", {s0[7], s1[7]}, 2'b11);
        chk("busy toggle oe", s0[6] ^ s1[6], 1);
        chk("susp toggle", s0[2] ^ s1[2], 1);
        i_host_model.rd(16'h4005, 1'b1, s0);
        chk("other bank", s0, arr(16'h4005));
        i_host_model.rd(16'h0405, 1'b1, s0);
        i_host_model.rd(16'h0405, 1'b1, s1);
        chk("busy toggle ce", s0[6] ^ s1[6], 1);
        chk("susp steady", s0[2] ^ s1[2], 0);
        wb(1, OFS_OP, 0);
        i_host_model.rd(16'h0305, 1'b0, s0);
        i_host_model.rd(16'h0305, 1'b0, s1);
        chk("done data", s0, arr(16'h0305));
        chk("done steady", s1, s0);
        $display("test status polling done");
        // Protected program: brief toggling, then stored data again
        wb(1, OFS_OP, 32'h0008_0000);
        i_host_model.rd(16'h0305, 1'b0, s0);
        i_host_model.rd(16'h0305, 1'b0, s1);
        chk("prot toggle", s0[6] ^ s1[6], 1);
        repeat (130) @(posedge clk_i);
        i_host_model.rd(16'h0305, 1'b0, s0);
        chk("prot after", s0, arr(16'h0305));
        $display("test protected program done");
        // Interrupt: sticky status, masking, read-only status, clear
        wb(0, OFS_IRQ_STAT, 0);
        chk("irq stat", rd_d, 7);
        wb(1, OFS_IRQ_EN, 0);
        repeat (2) @(posedge clk_i);
        chk("irq masked", irq, 0);
        wb(1, OFS_IRQ_EN, 4);
        repeat (2) @(posedge clk_i);
        chk("irq high", irq, 1);
        wb(1, OFS_IRQ_STAT, 0);
        wb(1, OFS_IRQ_CLR, 4);
        wb(0, OFS_IRQ_STAT, 0);
        chk("irq cleared", rd_d, 3);
        repeat (2) @(posedge clk_i);
        chk("irq low", irq, 0);
        i_host_model.rd(16'h4005, 1'b1, s0);
        repeat (2) @(posedge clk_i);
        chk("irq again", irq, 1);
        $display("test interrupt done");
        conclude();
    end
endmodule
